// [src/timer_block.sv]
// Two classic timers and a capture timer behind an APB slave
`include "timer_consts.svh"
module timer_block #(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_irq0_pin,
    input wire logic ext_irq1_pin,
    input wire logic t0_count_pin,
    input wire logic t1_count_pin,
    input wire logic third_count_pin_in,
    input wire logic ext_trigger_pin,
    output logic third_count_pin_out,
    output logic third_count_pin_oe,
    input wire logic t0_irq_ack,
    input wire logic t1_irq_ack,
    input wire logic ext_irq0_ack,
    input wire logic ext_irq1_ack,
    output logic t0_overflow_flag,
    output logic t1_overflow_flag,
    output logic ext_irq0_flag,
    output logic ext_irq1_flag,
    output logic third_irq_req,
    output logic uart_rx_clock,
    output logic uart_tx_clock
);
    logic t1_run_bit, t0_run_bit, ext_irq1_type, ext_irq0_type;
    logic [7:0] tmode_reg, t2mode_reg;
    timer_pkg::count_t cnt0, cnt1, cnt2, rcap, cap1;
    timer_pkg::count_t next_cnt0, next_cnt1, next_cnt2;
    logic t2_flag7, ext_trigger_flag, uart_rx_clock_select, uart_tx_clock_select;
    logic ext_trigger_enable, third_run_bit, third_source_select, capture_reload_select;
    logic [`NUM_PINS-1:0] pin_lvl, pin_fall, pin_rise;
    logic [3:0] cnt12, cnt4;
    logic tick12, tick4;
    logic [7:0] idx, wd, rd_val;
    logic hit, setup, access, wr_en;

    // All external pins pass the synchroniser before use
    pin_sync #(.N(`NUM_PINS)) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .pin({ext_trigger_pin, third_count_pin_in, t1_count_pin, t0_count_pin,
              ext_irq1_pin, ext_irq0_pin}),
        .level(pin_lvl),
        .fall(pin_fall),
        .rise(pin_rise)
    );

    // Advances one classic counter by one count in the given mode
    function automatic timer_pkg::step_t classic_step(input timer_pkg::count_t c,
                                                      input timer_pkg::tmode_t m);
        logic [13:0] s13;
        logic [16:0] s16;
        logic [8:0] s8;
        s13 = {1'b0, c.th, c.tl[4:0]} + 14'd1;
        s16 = {1'b0, c} + 17'd1;
        s8 = {1'b0, c.tl} + 9'd1;
        unique case (m)
            timer_pkg::MODE_13BIT: classic_step = {s13[13], s13[12:5], c.tl[7:5], s13[4:0]};
            timer_pkg::MODE_16BIT: classic_step = s16;
            timer_pkg::MODE_RELOAD8: classic_step = {s8[8], c.th, s8[8] ? c.th : s8[7:0]};
            timer_pkg::MODE_SPLIT: classic_step = {s8[8], c.th, s8[7:0]};
        endcase
    endfunction

    // Hardware set wins over any clear in the same cycle
    function automatic logic next_flag(input logic cur, input logic set, input logic clr,
                                       input logic wr, input logic wbit);
        next_flag = set | (wr ? wbit : (cur & ~clr));
    endfunction

    // Free-running prescalers for the standard and fast rates
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt12 <= 4'h0;
            cnt4 <= 4'h0;
        end else begin
            cnt12 <= tick12 ? 4'h0 : cnt12 + 4'd1;
            cnt4 <= tick4 ? 4'h0 : cnt4 + 4'd1;
        end
    end
    assign tick12 = (cnt12 == `DIV_STD - 4'd1);
    assign tick4 = (cnt4 == `DIV_FAST - 4'd1);

    // Internal clock tick for one timer given its fast bit
    function automatic logic clk_tick(input logic fast, input logic glb,
                                      input logic t12, input logic t4);
        clk_tick = fast ? (glb | t4) : t12;
    endfunction

    // APB decode; zero wait states
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign idx = paddr[9:2];
    assign wd = pwdata[7:0];
    assign pready = 1'b1;
    always_comb begin
        hit = 1'b0;
        if (paddr[1:0] == 2'h0 && paddr[ADDR_W-1:10] == '0) begin
            unique case (idx)
                `TIMER_CONTROL_IDX, `TIMER_MODE_SELECT_IDX, `T0_COUNT_LOW_IDX,
                `T1_COUNT_LOW_IDX, `T0_COUNT_HIGH_IDX, `T1_COUNT_HIGH_IDX,
                `THIRD_CONTROL_IDX, `THIRD_MODE_IDX, `RELOAD_LOW_IDX,
                `RELOAD_HIGH_IDX, `THIRD_COUNT_LOW_IDX, `THIRD_COUNT_HIGH_IDX: hit = 1'b1;
                default: hit = 1'b0;
            endcase
        end
    end
    assign pslverr = access & ~hit;
    assign wr_en = access & pwrite & pstrb[0] & hit;

    logic wr_timer_control, wr_timer_mode_select, wr_tl0, wr_tl1, wr_th0, wr_th1;
    logic wr_third_timer_control, wr_third_timer_mode, wr_rl, wr_rh, wr_cl, wr_ch;
    assign wr_timer_control = wr_en & (idx == `TIMER_CONTROL_IDX);
    assign wr_timer_mode_select = wr_en & (idx == `TIMER_MODE_SELECT_IDX);
    assign wr_tl0 = wr_en & (idx == `T0_COUNT_LOW_IDX);
    assign wr_tl1 = wr_en & (idx == `T1_COUNT_LOW_IDX);
    assign wr_th0 = wr_en & (idx == `T0_COUNT_HIGH_IDX);
    assign wr_th1 = wr_en & (idx == `T1_COUNT_HIGH_IDX);
    assign wr_third_timer_control = wr_en & (idx == `THIRD_CONTROL_IDX);
    assign wr_third_timer_mode = wr_en & (idx == `THIRD_MODE_IDX);
    assign wr_rl = wr_en & (idx == `RELOAD_LOW_IDX);
    assign wr_rh = wr_en & (idx == `RELOAD_HIGH_IDX);
    assign wr_cl = wr_en & (idx == `THIRD_COUNT_LOW_IDX);
    assign wr_ch = wr_en & (idx == `THIRD_COUNT_HIGH_IDX);

    // Classic timer controls and count events
    timer_pkg::tsel_t t0s, t1s;
    timer_pkg::step_t s0, s1;
    logic tk0, tk1, run0, run1, inc0, inc1, inc0h, split, c0h;
    logic ovf0, ovf0h, ovf1, t1_set, e0_set, e1_set;
    logic [7:0] th0_inc;
    always_comb begin
        t0s = timer_pkg::tsel_t'(tmode_reg[3:0]);
        t1s = timer_pkg::tsel_t'(tmode_reg[7:4]);
        tk0 = clk_tick(t2mode_reg[`T0_FAST_POS], t2mode_reg[`GLB_FAST_POS], tick12, tick4);
        tk1 = clk_tick(t2mode_reg[`T1_FAST_POS], t2mode_reg[`GLB_FAST_POS], tick12, tick4);
        split = (t0s.mode == timer_pkg::MODE_SPLIT);
        run0 = t0_run_bit & (~t0s.gate | pin_lvl[`PIN_IRQ0]);
        inc0 = run0 & (t0s.ctr ? pin_fall[`PIN_T0] : tk0);
        inc0h = split & t1_run_bit & tk0;
        run1 = (split | t1_run_bit) & (~t1s.gate | pin_lvl[`PIN_IRQ1]);
        inc1 = (t1s.mode != timer_pkg::MODE_SPLIT) & run1 & (t1s.ctr ? pin_fall[`PIN_T1] : tk1);
        s0 = classic_step(cnt0, t0s.mode);
        s1 = classic_step(cnt1, t1s.mode);
        {c0h, th0_inc} = {1'b0, cnt0.th} + 9'd1;
        ovf0 = inc0 & s0.ovf;
        ovf0h = inc0h & c0h;
        ovf1 = inc1 & s1.ovf;
        t1_set = split ? ovf0h : ovf1;
        next_cnt0.tl = inc0 ? s0.cnt.tl : cnt0.tl;
        if (split) begin
            next_cnt0.th = inc0h ? th0_inc : cnt0.th;
        end else begin
            next_cnt0.th = inc0 ? s0.cnt.th : cnt0.th;
        end
        next_cnt1 = inc1 ? s1.cnt : cnt1;
        e0_set = ext_irq0_type ? pin_fall[`PIN_IRQ0] : ~pin_lvl[`PIN_IRQ0];
        e1_set = ext_irq1_type ? pin_fall[`PIN_IRQ1] : ~pin_lvl[`PIN_IRQ1];
    end

    // Classic control register: flags, run bits, interrupt types
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {t1_overflow_flag, t1_run_bit, t0_overflow_flag, t0_run_bit} <= 4'h0;
            {ext_irq1_flag, ext_irq1_type, ext_irq0_flag, ext_irq0_type} <= 4'h0;
        end else begin
            t1_overflow_flag <= next_flag(t1_overflow_flag, t1_set, t1_irq_ack, wr_timer_control,
                                          wd[`T1_OVF_POS]);
            t0_overflow_flag <= next_flag(t0_overflow_flag, ovf0, t0_irq_ack, wr_timer_control,
                                          wd[`T0_OVF_POS]);
            ext_irq1_flag <= next_flag(ext_irq1_flag, e1_set, ext_irq1_ack, wr_timer_control,
                                       wd[`EXT1_FLAG_POS]);
            ext_irq0_flag <= next_flag(ext_irq0_flag, e0_set, ext_irq0_ack, wr_timer_control,
                                       wd[`EXT0_FLAG_POS]);
            if (wr_timer_control) begin
                t1_run_bit <= wd[`T1_RUN_POS];
                t0_run_bit <= wd[`T0_RUN_POS];
                ext_irq1_type <= wd[`EXT1_TYPE_POS];
                ext_irq0_type <= wd[`EXT0_TYPE_POS];
            end
        end
    end

    // Mode registers of both timer groups
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmode_reg <= `CTRL_RST;
            t2mode_reg <= `CTRL_RST;
        end else begin
            if (wr_timer_mode_select) tmode_reg <= wd;
            if (wr_third_timer_mode) t2mode_reg <= wd;
        end
    end

    // Classic counts; a software write overrides the count step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt0 <= {`COUNT_RST, `COUNT_RST};
            cnt1 <= {`COUNT_RST, `COUNT_RST};
        end else begin
            cnt0.tl <= wr_tl0 ? wd : next_cnt0.tl;
            cnt0.th <= wr_th0 ? wd : next_cnt0.th;
            cnt1.tl <= wr_tl1 ? wd : next_cnt1.tl;
            cnt1.th <= wr_th1 ? wd : next_cnt1.th;
        end
    end

    // Third timer events
    logic baud, cp_eff, tk2, inc2, c2, ovf2, trig, cap1_on, cap1_evt, f7_set;
    logic [15:0] cnt2_inc;
    always_comb begin
        baud = uart_rx_clock_select | uart_tx_clock_select;
        cp_eff = capture_reload_select & ~baud;
        tk2 = clk_tick(t2mode_reg[`T2_FAST_POS], t2mode_reg[`GLB_FAST_POS], tick12, tick4);
        inc2 = third_run_bit & (third_source_select ? pin_fall[`PIN_T2] : tk2);
        {c2, cnt2_inc} = {1'b0, cnt2} + 17'd1;
        ovf2 = inc2 & c2;
        trig = ext_trigger_enable & pin_fall[`PIN_EXT_TRIGGER_PIN];
        cap1_on = t2mode_reg[`CAP1_EN_POS] & ~baud & capture_reload_select
                  & ~third_source_select & ~t2mode_reg[`CLK_OE_POS];
        if (!t2mode_reg[`EDGE_LO_POS]) begin
            cap1_evt = cap1_on & pin_fall[`PIN_T2];
        end else if (t2mode_reg[`EDGE_HI_POS]) begin
            cap1_evt = cap1_on & pin_rise[`PIN_T2];
        end else begin
            cap1_evt = cap1_on & (pin_fall[`PIN_T2] | pin_rise[`PIN_T2]);
        end
        f7_set = cap1_on ? cap1_evt : (ovf2 & ~baud);
        if ((trig & ~cp_eff & ~baud) | (ovf2 & ~cp_eff)) begin
            next_cnt2 = rcap;
        end else if (inc2) begin
            next_cnt2 = cnt2_inc;
        end else begin
            next_cnt2 = cnt2;
        end
    end

    // Third timer control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {t2_flag7, ext_trigger_flag, uart_rx_clock_select, uart_tx_clock_select} <= 4'h0;
            {ext_trigger_enable, third_run_bit, third_source_select} <= 3'h0;
            capture_reload_select <= 1'b0;
        end else begin
            t2_flag7 <= next_flag(t2_flag7, f7_set, 1'b0, wr_third_timer_control, wd[`T2_FLAG7_POS]);
            ext_trigger_flag <= next_flag(ext_trigger_flag, trig, 1'b0, wr_third_timer_control,
                                          wd[`TRIG_FLAG_POS]);
            if (wr_third_timer_control) begin
                uart_rx_clock_select <= wd[`RX_SEL_POS];
                uart_tx_clock_select <= wd[`TX_SEL_POS];
                ext_trigger_enable <= wd[`TRIG_EN_POS];
                third_run_bit <= wd[`T2_RUN_POS];
                third_source_select <= wd[`T2_SRC_POS];
                capture_reload_select <= wd[`CAP_RL_POS];
            end
        end
    end

    // Third count, reload/capture pair and capture-one value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt2 <= {`COUNT_RST, `COUNT_RST};
            rcap <= {`COUNT_RST, `COUNT_RST};
            cap1 <= {`COUNT_RST, `COUNT_RST};
        end else begin
            cnt2.tl <= wr_cl ? wd : next_cnt2.tl;
            cnt2.th <= wr_ch ? wd : next_cnt2.th;
            if (trig & cp_eff) begin
                rcap <= cnt2;
            end else begin
                if (wr_rl) rcap.tl <= wd;
                if (wr_rh) rcap.th <= wd;
            end
            if (cap1_evt) cap1 <= cnt2;
        end
    end

    // Clock output toggles on each third-timer overflow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            third_count_pin_out <= 1'b0;
        end else if (!t2mode_reg[`CLK_OE_POS]) begin
            third_count_pin_out <= 1'b0;
        end else if (ovf2) begin
            third_count_pin_out <= ~third_count_pin_out;
        end
    end
    assign third_count_pin_oe = t2mode_reg[`CLK_OE_POS];

    // UART clock pulses and third-timer request
    assign uart_rx_clock = uart_rx_clock_select ? ovf2 : ovf1;
    assign uart_tx_clock = uart_tx_clock_select ? ovf2 : ovf1;
    assign third_irq_req = t2_flag7 | ext_trigger_flag;

    // Read multiplexer
    always_comb begin
        rd_val = 8'h00;
        unique case (idx)
            `TIMER_CONTROL_IDX: rd_val = {t1_overflow_flag, t1_run_bit, t0_overflow_flag,
                                          t0_run_bit, ext_irq1_flag, ext_irq1_type,
                                          ext_irq0_flag, ext_irq0_type};
            `TIMER_MODE_SELECT_IDX: rd_val = tmode_reg;
            `T0_COUNT_LOW_IDX: rd_val = cnt0.tl;
            `T1_COUNT_LOW_IDX: rd_val = cnt1.tl;
            `T0_COUNT_HIGH_IDX: rd_val = cnt0.th;
            `T1_COUNT_HIGH_IDX: rd_val = cnt1.th;
            `THIRD_CONTROL_IDX: rd_val = {t2_flag7, ext_trigger_flag, uart_rx_clock_select,
                                          uart_tx_clock_select, ext_trigger_enable,
                                          third_run_bit, third_source_select, cp_eff};
            `THIRD_MODE_IDX: rd_val = t2mode_reg;
            `RELOAD_LOW_IDX: rd_val = rcap.tl;
            `RELOAD_HIGH_IDX: rd_val = rcap.th;
            `THIRD_COUNT_LOW_IDX: rd_val = t2mode_reg[`CAP1_EN_POS] ? cap1.tl : cnt2.tl;
            `THIRD_COUNT_HIGH_IDX: rd_val = t2mode_reg[`CAP1_EN_POS] ? cap1.th : cnt2.th;
            default: rd_val = 8'h00;
        endcase
    end

    // Read data sampled in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (setup & ~pwrite) begin
            prdata <= {24'h0, hit ? rd_val : 8'h00};
        end
    end

    // Checks on the timer behaviour
    property p_t0_ovf;
        @(posedge pclk) disable iff (!presetn) ovf0 |=> t0_overflow_flag;
    endproperty
    a_t0_ovf: assert property (p_t0_ovf) else $error("t0 overflow flag not set");

    property p_ack_clear;
        @(posedge pclk) disable iff (!presetn)
            t1_irq_ack & ~t1_set & ~wr_timer_control |=> !t1_overflow_flag;
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("t1 flag survived ack");

    property p_run_hold;
        @(posedge pclk) disable iff (!presetn)
            !t0_run_bit & !split & !wr_tl0 & !wr_th0 |=> cnt0 == $past(cnt0);
    endproperty
    a_run_hold: assert property (p_run_hold) else $error("t0 counted while stopped");

    property p_gate;
        @(posedge pclk) disable iff (!presetn) t0s.gate & !pin_lvl[`PIN_IRQ0] |-> !inc0;
    endproperty
    a_gate: assert property (p_gate) else $error("t0 ran with gate pin low");

    sequence s_reload8_wrap;
        t0s.mode == timer_pkg::MODE_RELOAD8 && inc0 && cnt0.tl == 8'hff && !wr_tl0;
    endsequence
    property p_reload8;
        @(posedge pclk) disable iff (!presetn)
            s_reload8_wrap |=> cnt0.tl == $past(cnt0.th) && t0_overflow_flag;
    endproperty
    a_reload8: assert property (p_reload8) else $error("mode 2 reload missed");

    property p_mode0;
        @(posedge pclk) disable iff (!presetn)
            t0s.mode == timer_pkg::MODE_13BIT && inc0 && cnt0.th == 8'hff
            && cnt0.tl[4:0] == 5'h1f && !wr_tl0 && !wr_th0
            |=> cnt0.th == 8'h00 && cnt0.tl[4:0] == 5'h00 && t0_overflow_flag;
    endproperty
    a_mode0: assert property (p_mode0) else $error("mode 0 rollover wrong");

    property p_t1_stop;
        @(posedge pclk) disable iff (!presetn) t1s.mode == timer_pkg::MODE_SPLIT |-> !inc1;
    endproperty
    a_t1_stop: assert property (p_t1_stop) else $error("t1 counted in mode 3");

    property p_baud_no_flag;
        @(posedge pclk) disable iff (!presetn)
            baud & !cap1_on & !wr_third_timer_control & !t2_flag7 |=> !t2_flag7;
    endproperty
    a_baud_no_flag: assert property (p_baud_no_flag) else $error("third flag set in uart mode");

    property p_cap1;
        @(posedge pclk) disable iff (!presetn)
            cap1_evt |=> cap1 == $past(cnt2) && t2_flag7;
    endproperty
    a_cap1: assert property (p_cap1) else $error("capture one missed");

    property p_prescale;
        @(posedge pclk) disable iff (!presetn) tick12 |=> !tick12 [*8] ##4 tick12;
    endproperty
    a_prescale: assert property (p_prescale) else $error("standard tick period wrong");

    property p_uart_tx;
        @(posedge pclk) disable iff (!presetn)
            uart_tx_clock == (uart_tx_clock_select ? (inc2 & c2) : ovf1);
    endproperty
    a_uart_tx: assert property (p_uart_tx) else $error("uart tx clock source wrong");
endmodule

// [include/timer_consts.svh]
// Register indices, field positions, reset values and divider counts
// Contract
// - Overflow sets flag; interrupt entry clears it
// - Classic timer counts only while run bit set (timer one ignores its run bit while timer zero is in mode 3)
// - External interrupt type picks level or edge
// - Gate bit makes pin high required to run
// - Select bit picks internal clock or pin falls
// - Mode 0 is 13-bit counter, sets flag
// - Mode 1 is 16-bit counter, sets flag
// - Mode 2 reloads low byte from high
// - Mode 3 splits timer zero into two bytes
// - Timer one stops in its own mode 3
// - Third overflow flag, never in UART mode
// - Capture-one flag set by valid pin edge
// - Trigger edge acts only when trigger enabled
// - UART clocks pick timer one or third
// - Third timer source select and run bit
// - Capture select reads zero in UART mode
// - Edge field picks capture-one edges
// - Clock output enable drives third count pin
// - Capture-one enabled only under stated conditions
// - Reload register holds reload or trigger capture
// - Count addresses read capture-one when enabled
// - Third timer clock divides by 12, 4 or 1
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH
`define TIMER_CONTROL_IDX 8'h88
`define TIMER_MODE_SELECT_IDX 8'h89
`define T0_COUNT_LOW_IDX 8'h8a
`define T1_COUNT_LOW_IDX 8'h8b
`define T0_COUNT_HIGH_IDX 8'h8c
`define T1_COUNT_HIGH_IDX 8'h8d
`define THIRD_CONTROL_IDX 8'hc8
`define THIRD_MODE_IDX 8'hc9
`define RELOAD_LOW_IDX 8'hca
`define RELOAD_HIGH_IDX 8'hcb
`define THIRD_COUNT_LOW_IDX 8'hcc
`define THIRD_COUNT_HIGH_IDX 8'hcd
`define T1_OVF_POS 7
`define T1_RUN_POS 6
`define T0_OVF_POS 5
`define T0_RUN_POS 4
`define EXT1_FLAG_POS 3
`define EXT1_TYPE_POS 2
`define EXT0_FLAG_POS 1
`define EXT0_TYPE_POS 0
`define T2_FLAG7_POS 7
`define TRIG_FLAG_POS 6
`define RX_SEL_POS 5
`define TX_SEL_POS 4
`define TRIG_EN_POS 3
`define T2_RUN_POS 2
`define T2_SRC_POS 1
`define CAP_RL_POS 0
`define GLB_FAST_POS 7
`define T2_FAST_POS 6
`define T1_FAST_POS 5
`define T0_FAST_POS 4
`define EDGE_HI_POS 3
`define EDGE_LO_POS 2
`define CLK_OE_POS 1
`define CAP1_EN_POS 0
`define CTRL_RST 8'h00
`define COUNT_RST 8'h00
`define DIV_STD 4'd12
`define DIV_FAST 4'd4
`define PIN_IDLE 1'b1
`define NUM_PINS 6
`define PIN_IRQ0 0
`define PIN_IRQ1 1
`define PIN_T0 2
`define PIN_T1 3
`define PIN_T2 4
`define PIN_EXT_TRIGGER_PIN 5
`endif

// [include/timer_pkg.sv]
// Types shared by the timer block
package timer_pkg;
    typedef enum logic [1:0] {
        MODE_13BIT = 2'b00,
        MODE_16BIT = 2'b01,
        MODE_RELOAD8 = 2'b10,
        MODE_SPLIT = 2'b11
    } tmode_t;
    typedef struct packed {
        logic gate;
        logic ctr;
        tmode_t mode;
    } tsel_t;
    typedef struct packed {
        logic [7:0] th;
        logic [7:0] tl;
    } count_t;
    typedef struct packed {
        logic ovf;
        count_t cnt;
    } step_t;
endpackage

// [src/pin_sync.sv]
// Two-stage pin synchroniser with edge detection
`include "timer_consts.svh"
module pin_sync #(
    parameter int N = 6
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [N-1:0] pin,
    output logic [N-1:0] level,
    output logic [N-1:0] fall,
    output logic [N-1:0] rise
);
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_pin
            logic meta;
            logic sync;
            logic prev;
            // Meta stage feeds only the sync stage
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta <= `PIN_IDLE;
                    sync <= `PIN_IDLE;
                    prev <= `PIN_IDLE;
                end else begin
                    meta <= pin[i];
                    sync <= meta;
                    prev <= sync;
                end
            end
            assign level[i] = sync;
            assign fall[i] = prev & ~sync;
            assign rise[i] = ~prev & sync;
        end
    endgenerate
endmodule

// [verification/pin_partner.sv]
// Partner model of the external count, gate, trigger and interrupt pins
module pin_partner (
    input wire logic pclk,
    output logic [5:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins idle high, as with a pull-up
    initial pins = 6'h3f;
    // One low pulse, long enough to pass the pin synchroniser
    task automatic pulse(input int idx);
        @(posedge pclk);
        pins[idx] <= 1'b0;
        repeat (4) @(posedge pclk);
        pins[idx] <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask
endmodule

// [verification/dual_classic_and_capture_timers_test.sv]
// Self-checking bench for the timer block
`include "timer_consts.svh"
module dual_classic_and_capture_timers_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slv;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, ack0 = 0, eack0 = 0, f0, x0;
    logic [5:0] pv;
    logic [7:0] rd;
    int err_count = 0, samples_checked = 0, n;
    always #4 pclk = ~pclk;
    pin_partner pins (.pclk(pclk), .pins(pv));
    timer_block u_timer_block (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_irq0_pin(pv[`PIN_IRQ0]),
        .ext_irq1_pin(pv[`PIN_IRQ1]), .t0_count_pin(pv[`PIN_T0]), .t1_count_pin(pv[`PIN_T1]),
        .third_count_pin_in(pv[`PIN_T2]), .ext_trigger_pin(pv[`PIN_EXT_TRIGGER_PIN]),
        .third_count_pin_out(), .third_count_pin_oe(), .t0_irq_ack(ack0), .t1_irq_ack(1'b0),
        .ext_irq0_ack(eack0), .ext_irq1_ack(1'b0), .t0_overflow_flag(f0),
        .t1_overflow_flag(), .ext_irq0_flag(x0), .ext_irq1_flag(), .third_irq_req(),
        .uart_rx_clock(), .uart_tx_clock());
    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer: setup, then access until pready
    task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= {2'b00, idx, 2'b00};
        pwrite <= wr;
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata[7:0];
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            err_count++;
            close_out();
        end
    endtask
    task automatic t_reset;
        apb(`TIMER_CONTROL_IDX, 0, 0); chk(rd, 8'h00); // REG
        apb(`TIMER_MODE_SELECT_IDX, 0, 0); chk(rd, 8'h00); // REG
        apb(`THIRD_CONTROL_IDX, 0, 0); chk(rd, 8'h00); // REG
        apb(8'h00, 0, 0); chk({7'h0, slv}, 8'h01); // REG
        chk(rd, 8'h00); // REG
        $display("reset test done");
    endtask
    // Mode 2 on the undivided tick: overflow, reload, flag, ack clear
    task automatic t_reload;
        apb(`THIRD_MODE_IDX, 1, 8'h90);
        apb(`TIMER_MODE_SELECT_IDX, 1, 8'h02);
        apb(`T0_COUNT_HIGH_IDX, 1, 8'hfe);
        apb(`T0_COUNT_LOW_IDX, 1, 8'hfe);
        apb(`TIMER_CONTROL_IDX, 1, 8'h10);
        n = 0;
        while (f0 !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        chk({7'h0, f0}, 8'h01);
        if (n >= 200) close_out();
        apb(`TIMER_CONTROL_IDX, 1, 8'h20);
        apb(`T0_COUNT_LOW_IDX, 0, 0); chk({1'b0, rd[7:1]}, 8'h7f);
        apb(`TIMER_CONTROL_IDX, 0, 0); chk(rd, 8'h20);
        @(posedge pclk) ack0 <= 1'b1;
        @(posedge pclk) ack0 <= 1'b0;
        @(posedge pclk); chk({7'h0, f0}, 8'h00);
        $display("reload test done");
    endtask
    // Edge-type external interrupt, then cleared on entry
    task automatic t_edge;
        apb(`TIMER_CONTROL_IDX, 1, 8'h01);
        pins.pulse(`PIN_IRQ0);
        chk({7'h0, x0}, 8'h01);
        @(posedge pclk) eack0 <= 1'b1;
        @(posedge pclk) eack0 <= 1'b0;
        @(posedge pclk); chk({7'h0, x0}, 8'h00);
        $display("edge test done");
    endtask
    // Counter mode 1 on timer one: pin falls counted only while running
    task automatic t_count;
        apb(`TIMER_MODE_SELECT_IDX, 1, 8'h50);
        apb(`T1_COUNT_LOW_IDX, 1, 8'h00);
        apb(`TIMER_CONTROL_IDX, 1, 8'h40);
        for (int i = 0; i < 3; i++) pins.pulse(`PIN_T1);
        apb(`T1_COUNT_LOW_IDX, 0, 0); chk(rd, 8'h03);
        apb(`TIMER_CONTROL_IDX, 1, 8'h00);
        pins.pulse(`PIN_T1);
        apb(`T1_COUNT_LOW_IDX, 0, 0); chk(rd, 8'h03);
        $display("count test done");
    endtask
    // Third timer on the undivided tick: reload, flag, forced select, quiet flag in UART mode
    task automatic t_third;
        apb(`THIRD_MODE_IDX, 1, 8'hc0);
        apb(`RELOAD_LOW_IDX, 1, 8'hf0);
        apb(`RELOAD_HIGH_IDX, 1, 8'hff);
        apb(`THIRD_COUNT_LOW_IDX, 1, 8'hfe);
        apb(`THIRD_COUNT_HIGH_IDX, 1, 8'hff);
        apb(`THIRD_CONTROL_IDX, 1, 8'h04);
        repeat (20) @(posedge pclk);
        apb(`THIRD_CONTROL_IDX, 0, 0); chk(rd, 8'h84);
        apb(`THIRD_CONTROL_IDX, 1, 8'h80);
        apb(`THIRD_COUNT_HIGH_IDX, 0, 0); chk(rd, 8'hff);
        apb(`RELOAD_LOW_IDX, 0, 0); chk(rd, 8'hf0);
        apb(`THIRD_CONTROL_IDX, 1, 8'h31);
        apb(`THIRD_CONTROL_IDX, 0, 0); chk(rd, 8'h30);
        apb(`THIRD_CONTROL_IDX, 1, 8'h34);
        repeat (40) @(posedge pclk);
        apb(`THIRD_CONTROL_IDX, 0, 0); chk(rd, 8'h34);
        apb(`THIRD_CONTROL_IDX, 1, 8'h00);
        $display("third timer test done");
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_reload();
        t_edge();
        t_count();
        t_third();
        close_out();
    end
endmodule
